// ---- src/sar_adc_result_buffer.sv ----
// Converter result buffer with register port and interrupt
// Function
// - Reset clears full flag, sets empty flag
// - Buffer data read only; writes ignored
// - Buffer mode stores every completed conversion except one arriving while full with no read
// - Result right-justified in bits 11..0
// - Full flag when all 64 locations unread
// - Empty flag returned with last result
// - Bit 12 tags source group
// - Touch order Y,X then Z1,Z2
// - Auto-scan order first aux, second aux, temperature
// - Port-scan order battery, first aux, second aux
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_result_buffer #(
    parameter int DEPTH = result_buffer_pkg::BUFFER_DEPTH
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    // Converter side: one pulse per completed conversion
    input wire logic i_conv_done,
    input wire logic [11:0] i_conv_result,
    input wire logic [2:0] i_conv_source,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Buffer state and interrupt
    output logic o_buffer_mode,
    output logic o_order_error,
    output logic o_irq
);
    localparam int AW = $clog2(DEPTH);
    localparam int IW = result_buffer_pkg::IRQ_WIDTH;

    // Tag lookup, used only for the stored word; order tracking uses rank and source bit 2
    function automatic logic source_tag(input logic [2:0] src);
        case (src)
            result_buffer_pkg::SRC_Y, result_buffer_pkg::SRC_Z2,
            result_buffer_pkg::SRC_FIRST_AUX, result_buffer_pkg::SRC_TEMP:
                source_tag = result_buffer_pkg::TAG_GROUP_B;
            default: source_tag = result_buffer_pkg::TAG_GROUP_A;
        endcase
    endfunction : source_tag

    // Rank of a source within its scan sequence, lower comes first
    function automatic logic [1:0] source_rank(input logic [2:0] src);
        case (src)
            result_buffer_pkg::SRC_Y: source_rank = 2'h0;
            result_buffer_pkg::SRC_X: source_rank = 2'h1;
            result_buffer_pkg::SRC_Z1: source_rank = 2'h2;
            result_buffer_pkg::SRC_Z2: source_rank = 2'h3;
            result_buffer_pkg::SRC_BATTERY: source_rank = 2'h0;
            result_buffer_pkg::SRC_FIRST_AUX: source_rank = 2'h1;
            result_buffer_pkg::SRC_SECOND_AUX: source_rank = 2'h2;
            default: source_rank = 2'h3;
        endcase
    endfunction : source_rank

    logic buffer_mode;
    logic [IW-1:0] irq_status;
    logic [IW-1:0] irq_enable;
    logic [15:0] rdata;
    logic [2:0] last_source;
    logic last_valid;
    logic order_error;
    wire [12:0] head;
    wire [AW:0] count;
    wire full;
    wire empty;

    // Address decode
    wire sel_readout = (i_addr == result_buffer_pkg::ADDR_READOUT);
    wire sel_status = (i_addr == result_buffer_pkg::ADDR_STATUS);
    wire sel_enable = (i_addr == result_buffer_pkg::ADDR_IRQ_ENABLE);
    wire sel_clear = (i_addr == result_buffer_pkg::ADDR_IRQ_CLEAR);
    wire sel_control = (i_addr == result_buffer_pkg::ADDR_CONTROL);
    wire sel_level = (i_addr == result_buffer_pkg::ADDR_LEVEL);

    wire push = i_conv_done && buffer_mode;
    wire pop = i_rd && sel_readout && !empty;
    // Overrun: conversion arrives while full with no read to free room
    wire overrun = push && full && !pop;

    wire [12:0] push_word = {source_tag(i_conv_source), i_conv_result};

    // sequence position must rise within one scan
    wire new_scan = !last_valid || (source_rank(i_conv_source) == 2'h0)
        || (i_conv_source[2] != last_source[2]);
    wire out_of_order = push && !new_scan
        && (source_rank(i_conv_source) <= source_rank(last_source));

    // flags after this read; a push beside the pop keeps it full
    wire buffer_full_flag = full && (!pop || push);
    wire buffer_empty_flag = (count == {{AW{1'b0}}, 1'b1}) && !push;

    // reserved zero; word is full, empty, reserved, tag, result
    wire [15:0] readout_word = empty ? result_buffer_pkg::READOUT_RESET :
        {buffer_full_flag, buffer_empty_flag, 1'b0, head};

    // Selection of read data
    wire [15:0] rd_mux =
        sel_readout ? readout_word :
        sel_status ? {{(16-IW){1'b0}}, irq_status} :
        sel_enable ? {{(16-IW){1'b0}}, irq_enable} :
        sel_control ? {15'h0000, buffer_mode} :
        sel_level ? {{(15-AW){1'b0}}, count} :
        16'h0000;

    // Events that set sticky status bits
    wire [IW-1:0] irq_events = {!empty, overrun, full};
    wire [IW-1:0] irq_clear = (i_wr && sel_clear) ? i_wdata[IW-1:0] : '0;

    result_fifo_store #(
        .WIDTH(13),
        .DEPTH(DEPTH)
    ) u_store (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_push(push),
        .i_push_data(push_word),
        .i_pop(pop),
        .o_head(head),
        .o_count(count),
        .o_full(full),
        .o_empty(empty)
    );

    // reset word, read data registered one cycle after strobe
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rdata <= result_buffer_pkg::READOUT_RESET;
        end else if (i_rd) begin
            rdata <= rd_mux;
        end
    end

    // Control and interrupt enable registers; writes to the readout word are dropped
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            buffer_mode <= 1'b0;
            irq_enable <= '0;
        end else if (i_wr) begin
            if (sel_control) begin
                buffer_mode <= i_wdata[0];
            end else if (sel_enable) begin
                irq_enable <= i_wdata[IW-1:0];
            end
        end
    end

    // Sticky status: a set in the same cycle beats the clear
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    // Scan order tracking for sequencing checks
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            last_source <= 3'h0;
            last_valid <= 1'b0;
            order_error <= 1'b0;
        end else if (push) begin
            last_source <= i_conv_source;
            last_valid <= 1'b1;
            order_error <= out_of_order;
        end
    end

    assign o_rdata = rdata;
    assign o_buffer_mode = buffer_mode;
    assign o_order_error = order_error;
    // Level interrupt while any enabled status bit stands
    assign o_irq = |(irq_status & irq_enable);

    AST_RESET_FLAGS: assert property (@(posedge i_mclk)
        $fell(i_reset) |-> (o_rdata[15] == 1'b0) && (o_rdata[14] == 1'b1))
        else $error("reset readout flags wrong");

    // write to readout leaves level unchanged
    AST_WRITE_IGNORED: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_wr && sel_readout && !push) |=> (count == $past(count)))
        else $error("write changed buffer contents");

    // push raises occupancy when not full and no pop
    AST_STORE_ALL: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && !pop && !full) |=> (count == $past(count) + 1'b1))
        else $error("conversion not stored");

    AST_RESULT_FORMAT: assert property (@(posedge i_mclk) disable iff (i_reset)
        (pop) |=> (o_rdata[12:0] == $past(head)))
        else $error("readout result or tag misplaced");

    // read while full reports the full flag only with a push beside it
    AST_FULL_FLAG: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_rd && sel_readout && full) |=> (o_rdata[15] == $past(push)) && !o_rdata[14])
        else $error("full flag inconsistent");

    AST_EMPTY_LAST: assert property (@(posedge i_mclk) disable iff (i_reset)
        (pop && count == 1 && !push) |=> o_rdata[14] && empty)
        else $error("empty flag missing on last result");

    AST_TAG: assert property (@(posedge i_mclk) disable iff (i_reset)
        push |-> (push_word[12] == (i_conv_source == result_buffer_pkg::SRC_Y
            || i_conv_source == result_buffer_pkg::SRC_Z2
            || i_conv_source == result_buffer_pkg::SRC_FIRST_AUX
            || i_conv_source == result_buffer_pkg::SRC_TEMP)))
        else $error("source tag wrong");

    AST_FIFO_POP: assert property (@(posedge i_mclk) disable iff (i_reset)
        (pop && !push) |=> (count == $past(count) - 1'b1))
        else $error("read did not remove entry");

    // reserved bit reads as zero here
    AST_RESERVED: assert property (@(posedge i_mclk) disable iff (i_reset)
        $past(i_rd && sel_readout) |-> (o_rdata[13] == 1'b0))
        else $error("reserved bit set");

    // reset loads the empty readout word
    AST_RESET_WORD: assert property (@(posedge i_mclk)
        i_reset |=> (o_rdata == result_buffer_pkg::READOUT_RESET))
        else $error("readout word wrong after reset");

    AST_RESET_EMPTY: assert property (@(posedge i_mclk)
        i_reset |=> empty)
        else $error("store not empty after reset");

    AST_RESET_MODE: assert property (@(posedge i_mclk)
        i_reset |=> !o_buffer_mode)
        else $error("buffer mode set after reset");

    // write to readout leaves head entry alone
    AST_WRITE_HEAD: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_wr && sel_readout && !push && !pop) |=> $stable(head))
        else $error("write changed head entry");

    // nothing stored while buffer mode is off
    AST_MODE_OFF: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_conv_done && !buffer_mode && !pop) |=> (count == $past(count)))
        else $error("result stored with buffer mode off");

    // push beside a pop is kept
    AST_PUSH_POP: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && pop) |=> (count == $past(count)))
        else $error("push beside pop lost");

    // overrun leaves the store full and unchanged
    AST_OVERRUN_DROP: assert property (@(posedge i_mclk) disable iff (i_reset)
        overrun |=> full && (count == $past(count)))
        else $error("overrun changed store");

    AST_FIRST_ENTRY: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && empty) |=> (head[11:0] == $past(i_conv_result)))
        else $error("result bits misplaced");

    AST_FULL_HELD: assert property (@(posedge i_mclk) disable iff (i_reset)
        (full && !pop) |=> full)
        else $error("full dropped without read");

    // last free location fills the store
    AST_FULL_REACHED: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && !pop && (count == DEPTH - 1)) |=> full)
        else $error("full not reached");

    // no full bit unless the store was full
    AST_FULL_BIT_CLEAR: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_rd && sel_readout && !full) |=> !o_rdata[result_buffer_pkg::FULL_BIT])
        else $error("full bit set while not full");

    // read of empty store returns empty word
    AST_EMPTY_READ: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_rd && sel_readout && empty) |=> (o_rdata == result_buffer_pkg::READOUT_RESET))
        else $error("empty read word wrong");

    // no empty bit while entries remain
    AST_EMPTY_BIT_CLEAR: assert property (@(posedge i_mclk) disable iff (i_reset)
        (pop && (count > 1)) |=> !o_rdata[result_buffer_pkg::EMPTY_BIT])
        else $error("empty bit set with data left");

    AST_EMPTY_STAYS: assert property (@(posedge i_mclk) disable iff (i_reset)
        (empty && !push) |=> empty)
        else $error("empty dropped without push");

    // Y then X is in order
    AST_TOUCH_ORDER: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && last_valid && last_source == result_buffer_pkg::SRC_Y
            && i_conv_source == result_buffer_pkg::SRC_X) |=> !order_error)
        else $error("Y then X flagged");

    // Z1 then Z2 is in order
    AST_TOUCH_Z_ORDER: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && last_valid && last_source == result_buffer_pkg::SRC_Z1
            && i_conv_source == result_buffer_pkg::SRC_Z2) |=> !order_error)
        else $error("Z1 then Z2 flagged");

    // X after Z1 breaks touch order
    AST_TOUCH_REVERSED: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && last_valid && last_source == result_buffer_pkg::SRC_Z1
            && i_conv_source == result_buffer_pkg::SRC_X) |=> order_error)
        else $error("X after Z1 not flagged");

    // second aux then temperature is in order
    AST_SCAN_ORDER: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && last_valid && last_source == result_buffer_pkg::SRC_SECOND_AUX
            && i_conv_source == result_buffer_pkg::SRC_TEMP) |=> !order_error)
        else $error("auto scan order flagged");

    // skipped input is not an error
    AST_SCAN_SKIP: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && last_valid && last_source == result_buffer_pkg::SRC_FIRST_AUX
            && i_conv_source == result_buffer_pkg::SRC_TEMP) |=> !order_error)
        else $error("auto scan skip flagged");

    // battery then first aux is in order
    AST_PORT_ORDER: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && last_valid && last_source == result_buffer_pkg::SRC_BATTERY
            && i_conv_source == result_buffer_pkg::SRC_FIRST_AUX) |=> !order_error)
        else $error("port scan order flagged");

    // first aux after second aux breaks order
    AST_PORT_REVERSED: assert property (@(posedge i_mclk) disable iff (i_reset)
        (push && last_valid && last_source == result_buffer_pkg::SRC_SECOND_AUX
            && i_conv_source == result_buffer_pkg::SRC_FIRST_AUX) |=> order_error)
        else $error("reversed aux order not flagged");

    // only a readout read removes an entry
    AST_OTHER_READ: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_rd && !sel_readout && !push) |=> (count == $past(count)))
        else $error("other read removed entry");

    // read data stand until the next read
    AST_READ_STANDS: assert property (@(posedge i_mclk) disable iff (i_reset)
        !i_rd |=> $stable(o_rdata))
        else $error("read data changed without read");
endmodule : sar_adc_result_buffer
`default_nettype wire

// ---- src/result_buffer_pkg.sv ----
// Package: constants for the converter result buffer
package result_buffer_pkg;
    // Register map (word index on the plain register port)
    localparam logic [3:0] ADDR_READOUT = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h2;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_LEVEL = 4'h5;
    // Readout word field positions
    localparam int FULL_BIT = 15;
    localparam int EMPTY_BIT = 14;
    localparam int RSVD_BIT = 13;
    localparam int TAG_BIT = 12;
    localparam int RESULT_MSB = 11;
    // Sizes and reset values
    localparam int RESULT_WIDTH = 12;
    localparam int BUFFER_DEPTH = 64;
    localparam logic [15:0] READOUT_RESET = 16'h4000;
    // Interrupt status bits
    localparam int IRQ_FULL = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_NOT_EMPTY = 2;
    localparam int IRQ_WIDTH = 3;
    // Source tag encodings
    localparam logic TAG_GROUP_A = 1'b0;
    localparam logic TAG_GROUP_B = 1'b1;
    // Conversion sources
    typedef enum logic [2:0] {
        SRC_X = 3'h0, SRC_Y = 3'h1, SRC_Z1 = 3'h2, SRC_Z2 = 3'h3,
        SRC_BATTERY = 3'h4, SRC_FIRST_AUX = 3'h5, SRC_SECOND_AUX = 3'h6,
        SRC_TEMP = 3'h7
    } source_type;
endpackage : result_buffer_pkg

// ---- src/result_fifo_store.sv ----
// Flip-flop storage of tagged results with full and empty tracking
`timescale 1ns/1ps
`default_nettype none
module result_fifo_store #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 64
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_push_data,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_head,
    output logic [$clog2(DEPTH):0] o_count,
    output logic o_full,
    output logic o_empty
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire do_push;
    wire do_pop;

    // A pop on a full store makes room, so a push alongside it is kept
    assign do_pop = i_pop && (count != '0);
    assign do_push = i_push && ((count != DEPTH[AW:0]) || do_pop);
    assign o_head = mem[rd_ptr];
    assign o_count = count;
    assign o_full = (count == DEPTH[AW:0]);
    assign o_empty = (count == '0);

    // Data array write
    always_ff @(posedge i_mclk) begin
        if (do_push) begin
            mem[wr_ptr] <= i_push_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
        end
    end
endmodule : result_fifo_store
`default_nettype wire

// ---- dv/adc_conversion_model.sv ----
// Converter model issuing conversion results in the source order set by the kind, including one out-of-order kind
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_model (
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic [2:0] i_kind,
    input wire logic [11:0] i_value,
    output logic o_conv_done,
    output logic [11:0] o_conv_result,
    output var result_buffer_pkg::source_type o_conv_source,
    output logic o_busy
);
    logic [11:0] order;
    int len;
    // scan orders; first source sits in the low bits
    always_comb begin
        case (i_kind)
            3'h0: begin order = 12'h001; len = 2; end // Y, X
            3'h1: begin order = 12'h681; len = 4; end // Y, X, Z1, Z2
            3'h2: begin order = 12'h1F5; len = 3; end // First aux, second aux, temp
            3'h3: begin order = 12'h1AC; len = 3; end // Battery, first aux, second aux
            3'h5: begin order = 12'h03D; len = 2; end // Auto scan, second aux skipped
            3'h6: begin order = 12'h002; len = 2; end // Z1 then X, out of order
            default: begin order = 12'h000; len = 1; end // Single X
        endcase
    end
    // One result per two cycles, so the buffer sees every strobe apart
    initial begin
        o_conv_done = 1'b0;
        o_conv_result = 12'h000;
        o_conv_source = result_buffer_pkg::SRC_X;
        o_busy = 1'b0;
        forever begin
            @(posedge i_mclk);
            if (i_go === 1'b1) begin
                o_busy <= 1'b1;
                for (int k = 0; k < len; k++) begin
                    o_conv_done <= 1'b1;
                    o_conv_result <= 12'(i_value + 12'(k));
                    o_conv_source <= result_buffer_pkg::source_type'(order[3*k +: 3]);
                    @(posedge i_mclk);
                    o_conv_done <= 1'b0;
                    // Idle lines flip so a stale result is never taken for data
                    o_conv_result <= ~o_conv_result;
                    @(posedge i_mclk);
                end
                o_busy <= 1'b0;
            end
        end
    end
endmodule : adc_conversion_model
`default_nettype wire

// ---- dv/sar_adc_result_buffer_test.sv ----
// Self-checking bench for the converter result buffer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_result_buffer_test;
    logic i_mclk, i_reset, i_wr, i_rd, go, conv_done, busy, mode, order_err, irq;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, o_rdata, rv;
    logic [2:0] kind;
    logic [11:0] value, conv_result;
    result_buffer_pkg::source_type conv_source;
    int error_cnt, n_tests;
    sar_adc_result_buffer i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_conv_done(conv_done),
        .i_conv_result(conv_result), .i_conv_source(conv_source), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_buffer_mode(mode), .o_order_error(order_err), .o_irq(irq));
    adc_conversion_model i_conv (.i_mclk(i_mclk), .i_go(go), .i_kind(kind), .i_value(value),
        .o_conv_done(conv_done), .o_conv_result(conv_result), .o_conv_source(conv_source),
        .o_busy(busy));
    // Free-running 125 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    // Read data appear in the cycle after the strobe and stand until the next read
    task automatic rd(input logic [3:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask : rd
    task automatic conv(input logic [2:0] k, input logic [11:0] v);
        @(posedge i_mclk);
        go <= 1'b1;
        kind <= k;
        value <= v;
        @(posedge i_mclk);
        go <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge i_mclk);
            #1;
            if (busy === 1'b0) return;
        end
        error_cnt++;
        tally_and_finish();
    endtask : conv
    // Group B sources: Y, Z2, first aux, temperature
    function automatic logic tag_of(input logic [2:0] s);
        return s == 3'h1 || s == 3'h3 || s == 3'h5 || s == 3'h7;
    endfunction : tag_of
    task automatic seq(input logic [2:0] k, input int n, input logic [11:0] order,
            input logic [11:0] v, input logic err);
        conv(k, v);
        chk({15'h0000, order_err}, {15'h0000, err});
        for (int i = 0; i < n; i++) begin
            rd(result_buffer_pkg::ADDR_READOUT);
            chk(rv, {1'b0, i == n - 1, 1'b0, tag_of(order[3*i +: 3]), 12'(v + 12'(i))});
        end
    endtask : seq
    task automatic t_reset;
        #1 chk(o_rdata, 16'h4000);
        rd(result_buffer_pkg::ADDR_READOUT);
        chk(rv, 16'h4000);
        rd(4'hF);
        chk(rv, 16'h0000);
        conv(3'h4, 12'h123);
        rd(result_buffer_pkg::ADDR_READOUT);
        chk(rv, 16'h4000);
        wr(result_buffer_pkg::ADDR_CONTROL, 16'h0001);
        #1 chk({15'h0000, mode}, 16'h0001);
    endtask : t_reset
    task automatic t_readonly;
        conv(3'h4, 12'hABC);
        wr(result_buffer_pkg::ADDR_READOUT, 16'hFFFF);
        rd(result_buffer_pkg::ADDR_READOUT);
        chk(rv, 16'h4ABC);
    endtask : t_readonly
    task automatic t_orders;
        seq(3'h0, 2, 12'h001, 12'hFFE, 1'b0);
        seq(3'h1, 4, 12'h681, 12'h010, 1'b0);
        seq(3'h2, 3, 12'h1F5, 12'h200, 1'b0);
        seq(3'h5, 2, 12'h03D, 12'h300, 1'b0);
        seq(3'h3, 3, 12'h1AC, 12'h400, 1'b0);
        seq(3'h6, 2, 12'h002, 12'h500, 1'b1);
    endtask : t_orders
    task automatic t_fill;
        wr(result_buffer_pkg::ADDR_IRQ_ENABLE, 16'h0001);
        for (int i = 0; i < 64; i++) conv(3'h4, 12'(i));
        rd(result_buffer_pkg::ADDR_LEVEL);
        chk(rv, 16'h0040);
        chk({15'h0000, irq}, 16'h0001);
        conv(3'h4, 12'h777);
        rd(result_buffer_pkg::ADDR_STATUS);
        chk(rv, 16'h0007);
        wr(result_buffer_pkg::ADDR_IRQ_ENABLE, 16'h0000);
        #1 chk({15'h0000, irq}, 16'h0000);
        // A read and a push on one edge keep the buffer full
        @(posedge i_mclk);
        go <= 1'b1;
        value <= 12'h0AA;
        @(posedge i_mclk);
        go <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= result_buffer_pkg::ADDR_READOUT;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, 16'h8000);
        repeat (3) @(posedge i_mclk);
        for (int i = 1; i < 64; i++) begin
            rd(result_buffer_pkg::ADDR_READOUT);
            chk(rv, 16'(i));
        end
        rd(result_buffer_pkg::ADDR_READOUT);
        chk(rv, 16'h40AA);
        wr(result_buffer_pkg::ADDR_IRQ_CLEAR, 16'h0007);
        wr(result_buffer_pkg::ADDR_IRQ_ENABLE, 16'h0007);
        rd(result_buffer_pkg::ADDR_STATUS);
        chk(rv, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
    endtask : t_fill
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // Main sequence, reset held for five cycles
    initial begin
        i_reset = 1'b1;
        {i_wr, i_rd, go} = 3'b000;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        kind = 3'h4;
        value = 12'h000;
        error_cnt = 0;
        n_tests = 0;
        repeat (5) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_reset();
        t_readonly();
        t_orders();
        t_fill();
        tally_and_finish();
    end
endmodule : sar_adc_result_buffer_test
`default_nettype wire
